/* logic/smh_pkg.sv */
// shared constants for the serial modem handshake block
package smh_pkg;
  // handshake sequencing states
  typedef enum logic [1:0] {
    SMH_IDLE,
    SMH_LINKED,
    SMH_SENDING
  } smh_state_t;
  // reset values of the driven lines and the synchroniser flops
  localparam logic SMH_DTR_RST = 1'h0;
  localparam logic SMH_RTS_RST = 1'h0;
  localparam logic SMH_SYNC_RST = 1'h0;
  localparam logic SMH_START_RST = 1'h0;
  // synchroniser depth in flip-flops
  localparam int SMH_SYNC_STAGES = 2;
endpackage : smh_pkg

/* logic/smh_handshake.sv */
// terminal-side hardware handshake control for an asynchronous serial port

module smh_handshake (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic clk_en,
  // local status
  input wire logic port_powered,
  input wire logic rx_can_accept,
  // modem lines from the far party
  input wire logic dsr_in,
  input wire logic cts_in,
  input wire logic dcd_in,
  // modem lines toward the far party
  output logic dtr_out,
  output logic rts_out,
  // transmitter control
  input wire logic tx_queued,
  input wire logic tx_busy,
  output logic tx_start,
  output logic link_up
);

  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic dsr_s;
  logic cts_s;
  logic dcd_s;
  logic linked_next;
  smh_pkg::smh_state_t state_reg;

  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= {3{smh_pkg::SMH_SYNC_RST}};
      sync2_reg <= {3{smh_pkg::SMH_SYNC_RST}};
    end else if (clk_en) begin
      sync1_reg <= {dcd_in, cts_in, dsr_in};
      sync2_reg <= sync1_reg;
    end
  end

  assign dsr_s = sync2_reg[0];
  assign cts_s = sync2_reg[1];
  assign dcd_s = sync2_reg[2];

  // status levels only, so arrival order does not matter
  assign linked_next = dtr_out && dsr_s && dcd_s;

  // equipment ready output
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dtr_out <= smh_pkg::SMH_DTR_RST;
    end else if (clk_en) begin
      dtr_out <= port_powered;
    end
  end

  // receive readiness, raised only once the link is up
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rts_out <= smh_pkg::SMH_RTS_RST;
    end else if (clk_en) begin
      rts_out <= linked_next && rx_can_accept;
    end
  end

  // link sequencing
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= smh_pkg::SMH_IDLE;
    end else if (clk_en) begin
      unique case (state_reg)
        smh_pkg::SMH_IDLE: begin
          if (linked_next) begin
            state_reg <= smh_pkg::SMH_LINKED;
          end
        end
        smh_pkg::SMH_LINKED: begin
          if (!linked_next) begin
            state_reg <= smh_pkg::SMH_IDLE;
          end else if (tx_start) begin
            state_reg <= smh_pkg::SMH_SENDING;
          end
        end
        smh_pkg::SMH_SENDING: begin
          // finish the character in flight even if cts drops
          if (!tx_busy && !tx_start) begin
            state_reg <= linked_next ? smh_pkg::SMH_LINKED : smh_pkg::SMH_IDLE;
          end
        end
        default: begin // unused fourth code falls back to idle
          state_reg <= smh_pkg::SMH_IDLE;
        end
      endcase
    end
  end

  assign link_up = (state_reg != smh_pkg::SMH_IDLE);

  // start pulse of one enabled cycle, held while the enable is low; cts gates only starts, never a character in flight
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_start <= smh_pkg::SMH_START_RST;
    end else if (clk_en) begin
      tx_start <= linked_next && link_up && cts_s && tx_queued && !tx_busy
                  && !tx_start;
    end
  end

  // a start needs cts as seen at the enabled edge that launched it
  a_start_needs_cts: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(tx_start) |-> $past(cts_s) && $past(clk_en))
    else $error("start issued without cts");

  // only the rise counts, a pulse held by a low enable is not a new start
  a_start_needs_dsr: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(tx_start) |-> $past(dsr_s))
    else $error("start issued without dsr");

  // cts low at an enabled edge blocks the next start
  a_cts_low_blocks: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && !cts_s) |=> !tx_start)
    else $error("start after cts low");

  // dtr tracks power one enabled edge later
  a_dtr_follows_power: assert property (@(posedge ref_clk) disable iff (!resetn)
    clk_en |=> dtr_out == $past(port_powered))
    else $error("dtr not following power");

  // an unpowered port never claims readiness
  a_dtr_low_unpowered: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && !port_powered) |=> !dtr_out)
    else $error("dtr high while unpowered");

  // throttling must never touch dtr, so a powered port keeps it up
  a_dtr_ignores_cts: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && port_powered) |=> dtr_out)
    else $error("dtr dropped while powered");

  // checked at enabled edges only, since rts holds while the enable is low
  a_rts_needs_link: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && !(dtr_out && dsr_s && dcd_s)) |=> !rts_out)
    else $error("rts without link");

  // a full receiver withdraws rts
  a_rts_drops_busy: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && !rx_can_accept) |=> !rts_out)
    else $error("rts high while receiver full");

  // rts comes back once the receiver can take data
  a_rts_returns: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && rx_can_accept && linked_next) |=> rts_out)
    else $error("rts not reasserted");

  // rts means able to listen, whether or not anything waits to go out
  a_rts_ignores_queue: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && linked_next && rx_can_accept && !tx_queued) |=> rts_out)
    else $error("rts tied to queued data");

  // two enabled edges bring a pin level to the logic
  a_sync_delay: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en [*2]) |=> cts_s == $past(cts_in, 2))
    else $error("cts synchroniser depth wrong");

  // same depth for the readiness line
  a_sync_dsr_delay: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en [*2]) |=> dsr_s == $past(dsr_in, 2))
    else $error("dsr synchroniser depth wrong");

  // same depth for the carrier line
  a_sync_dcd_delay: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en [*2]) |=> dcd_s == $past(dcd_in, 2))
    else $error("dcd synchroniser depth wrong");

  // queued data goes out as soon as every condition holds
  a_queue_starts: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && link_up && linked_next && cts_s && tx_queued && !tx_busy && !tx_start)
      |=> tx_start)
    else $error("queued data not started");

  // starts never back to back, so the shifter sees one pulse per character
  a_start_single_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && tx_start) |=> !tx_start)
    else $error("start pulse too long");

  // no start while a character is still shifting
  a_no_start_busy: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && tx_busy) |=> !tx_start)
    else $error("start while shifter busy");

  // a character in flight keeps the sending state
  a_hold_in_flight: assert property (@(posedge ref_clk) disable iff (!resetn)
    (state_reg == smh_pkg::SMH_SENDING && tx_busy) |=> state_reg == smh_pkg::SMH_SENDING)
    else $error("character in flight abandoned");

  // a start on a live link moves into sending
  a_enter_sending: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && state_reg == smh_pkg::SMH_LINKED && linked_next && tx_start)
      |=> state_reg == smh_pkg::SMH_SENDING)
    else $error("start did not enter sending");

  // link stays down until dtr, dsr and dcd are all up; cts plays no part
  a_link_waits_status: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && state_reg == smh_pkg::SMH_IDLE && !linked_next) |=> !link_up)
    else $error("link up without status");

  // link comes up on levels, whichever side was ready first
  a_link_any_order: assert property (@(posedge ref_clk) disable iff (!resetn)
    (clk_en && state_reg == smh_pkg::SMH_IDLE && linked_next) |=> link_up)
    else $error("link not raised on ready levels");

  // a start also needs carrier and local readiness
  a_start_needs_dcd: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(tx_start) |-> $past(dcd_s) && $past(dtr_out))
    else $error("start issued without carrier");

endmodule : smh_handshake

/* verification/smh_far_end.sv */
// far terminal reached through a null-modem cable
module smh_far_end (
  // far side controls
  input wire logic far_pwr,
  input wire logic far_ok,
  // lines toward the port
  output logic dsr_pin,
  output logic cts_pin,
  output logic dcd_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // far rts means it can listen; delay keeps pins off the clock edge
  assign #37 cts_pin = far_pwr & far_ok;
  assign #37 dcd_pin = far_pwr & far_ok;
  assign #37 dsr_pin = far_pwr;
endmodule : smh_far_end

/* verification/smh_tb.sv */
// bench for the handshake block with a reference model
module serial_modem_handshake_control_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, resetn = 0, clk_en = 1, pwr = 0, rx_ok = 0, far_pwr = 0, far_ok = 0;
  logic tx_queued = 0, tx_busy = 0, dsr, cts, dcd, dtr, rts, tx_start, link_up;
  logic [2:0] s1, s2;
  logic e_dtr, e_rts, p_ok, e_start;
  int error_cnt = 0, checked = 0, cyc = 0, left = 0, starts = 0, e_st = 0;
  wire lk = e_dtr & s2[2] & s2[0];
  initial forever #50 ref_clk = ~ref_clk;
  smh_far_end far (.far_pwr(far_pwr), .far_ok(far_ok), .dsr_pin(dsr), .cts_pin(cts),
    .dcd_pin(dcd));
  smh_handshake DUT (.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .port_powered(pwr),
    .rx_can_accept(rx_ok), .dsr_in(dsr), .cts_in(cts), .dcd_in(dcd), .dtr_out(dtr),
    .rts_out(rts), .tx_queued(tx_queued), .tx_busy(tx_busy), .tx_start(tx_start),
    .link_up(link_up));
  // model: two-flop sync, then registered lines and start permission
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      {s1, s2, e_dtr, e_rts, p_ok, e_start} <= 10'h0;
      e_st <= 0;
    end else if (clk_en) begin
      s1 <= {dsr, cts, dcd};
      s2 <= s1;
      e_dtr <= pwr;
      e_rts <= e_dtr & s2[2] & s2[0] & rx_ok;
      p_ok <= e_dtr & (&s2) & tx_queued & !tx_busy;
      // link: 0 down, 1 up, 2 character out; starts never back to back
      e_start <= lk & (e_st != 0) & s2[1] & tx_queued & !tx_busy & !e_start;
      case (e_st)
        0: e_st <= int'(lk);
        1: e_st <= !lk ? 0 : (e_start ? 2 : 1);
        default: if (!tx_busy && !e_start) e_st <= int'(lk);
      endcase
    end
  end
  task automatic check(input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: value differs from model", $time);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // compare settled outputs mid-cycle; also the hang limit
  always @(negedge ref_clk) begin
    cyc++;
    if (cyc > 3000) begin
      error_cnt++;
      finish_test();
    end else if (resetn) begin
      check(dtr, e_dtr);
      check(rts, e_rts);
      if (tx_start === 1'b1) check(p_ok, 1'b1);
      check(tx_start, e_start);
      check(link_up, e_st != 0);
    end
  end
  // drive just after the edge; shifter stays busy even if cts drops
  task automatic step(input int n, input bit rnd);
    logic [3:0] flip;
    repeat (n) begin
      @(posedge ref_clk);
      #10;
      starts += (tx_start === 1'b1);
      if (tx_start === 1'b1) left = 2 + $urandom % 4;
      else if (left > 0) left--;
      tx_busy = left > 0;
      if (rnd) begin
        flip = ($urandom % 12 == 0) ? 4'($urandom) : 4'h0;
        {pwr, rx_ok, far_pwr, far_ok} = {pwr, rx_ok, far_pwr, far_ok} ^ flip;
        tx_queued = 1'($urandom);
        clk_en = ($urandom % 8) != 0;
      end
    end
  endtask
  initial begin
    void'($urandom(65886));
    step(4, 0);
    resetn = 1;
    step(600, 1);
    {pwr, rx_ok, far_pwr, far_ok, clk_en, tx_queued} = 6'h3f;
    step(8, 0);
    starts = 0;
    step(30, 0);
    check(starts > 2, 1'b1);
    far_ok = 0;
    step(4, 0);
    starts = 0;
    step(20, 0);
    check(starts == 0, 1'b1);
    resetn = 0;
    step(2, 0);
    resetn = 1;
    step(300, 1);
    finish_test();
  end
endmodule : serial_modem_handshake_control_bench
